//--- core/phyirq_regs.sv
// PHY event enable/status and auto-negotiation diagnostic registers on the management port
`timescale 1ns/1ps
`default_nettype none
`include "phyirq_map.svh"

// Function
// - Jabber event sets status bit 7; enable bit 15 gates its interrupt.
// - Receive error sets status bit 6; enable bit 14 gates its interrupt.
// - New page received sets status bit 5; enable bit 13 gates interrupt.
// - Parallel detection fault sets status bit 4; enable bit 12 gates interrupt.
// - Partner acknowledge burst sets status bit 3; enable bit 11 gates interrupt.
// - Link OK to FAIL sets status bit 2; enable bit 10 gates interrupt.
// - Partner remote fault sets status bit 1; enable bit 9 gates interrupt.
// - Negotiation completed sets status bit 0; enable bit 8 gates interrupt.
// - Reading the event register clears all eight status bits, except any bit set by an event on the same edge.
// - Each upper-byte enable lets its lower-byte status raise the PHY interrupt.
// - Negotiation failure bit 12 sets on no common mode, clears on read.
// - Bit 11 reads 1 for full duplex, 0 for half duplex.
// - Bit 10 reads 1 for 100 Mb/s, 0 for 10 Mb/s.
// - Bit 9 reads 1 when receive signal or Manchester data is detected.
// - Bit 8 reads 1 while the receive PLL is locked.
// - Diagnostic bits 15:13 and 7:0 read zero; software preserves them.
// - Diagnostic register at 0x12, read-only except failure bit, resets zero.
module phyirq_regs (
  input wire logic mclk, // Clock
  input wire logic srst, // Sync reset, high
  input wire phyirq_pkg::phyirq_mreq_s mreq, // Management request
  input wire phyirq_pkg::phyirq_event_s events, // Event pulses
  input wire phyirq_pkg::phyirq_neg_s neg, // Negotiation outcome
  input wire logic rx_sd, // Receive signal detect
  input wire logic rx_lock, // Receive PLL lock
  output logic mack, // Request answered
  output logic [15:0] mrdata, // Read data
  output logic phy_irq // To MAC, registered OR of enabled status flags
);

  localparam int N = `PHYIRQ_EVT_COUNT;
  localparam logic [15:0] EVT_RESET = `PHYIRQ_EVT_RESET;

  logic [N-1:0] event_en_reg;
  logic [N-1:0] event_flag;
  logic [15:0] diag_word;
  logic [15:0] evt_word;
  logic [15:0] rdata_next;
  logic mack_reg;
  logic [15:0] mrdata_reg;
  logic phy_irq_reg;
  logic sel_evt;
  logic sel_diag;
  logic rd_evt;
  logic rd_diag;
  logic wr_evt;

  assign sel_evt = mreq.addr == `PHYIRQ_EVT_ADDR;
  assign sel_diag = mreq.addr == `PHYIRQ_DIAG_ADDR;
  assign rd_evt = mreq.req && !mreq.we && sel_evt;
  assign rd_diag = mreq.req && !mreq.we && sel_diag;
  assign wr_evt = mreq.req && mreq.we && sel_evt;

  phyirq_flags #(
    .N(N)
  ) u_flags (
    .mclk(mclk),
    .srst(srst),
    .set_pulse(events),
    .clear_all(rd_evt),
    .flag(event_flag)
  );

  phyirq_diag u_diag (
    .mclk(mclk),
    .srst(srst),
    .neg(neg),
    .rx_sd(rx_sd),
    .rx_lock(rx_lock),
    .clear_fail(rd_diag),
    .diag_word(diag_word)
  );

  // Status byte is read-clear only; writes touch just the enables
  always_ff @(posedge mclk) begin
    if (srst) begin
      event_en_reg <= EVT_RESET[`PHYIRQ_EVT_EN_LSB +: N];
    end else if (wr_evt) begin
      event_en_reg <= mreq.wdata[`PHYIRQ_EVT_EN_LSB +: N];
    end
  end

  always_comb begin
    evt_word = {event_en_reg, event_flag};
    if (sel_evt) begin
      rdata_next = evt_word;
    end else if (sel_diag) begin
      rdata_next = diag_word;
    end else begin
      rdata_next = `PHYIRQ_UNMAPPED_READ;
    end
  end

  // Every request is answered one cycle later, unmapped ones too
  always_ff @(posedge mclk) begin
    if (srst) begin
      mack_reg <= 1'b0;
    end else begin
      mack_reg <= mreq.req;
    end
  end

  // Data captured on the same edge that clears, so no flag is read twice or missed
  always_ff @(posedge mclk) begin
    if (srst) begin
      mrdata_reg <= 16'h0000;
    end else if (mreq.req && !mreq.we) begin
      mrdata_reg <= rdata_next;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      phy_irq_reg <= 1'b0;
    end else begin
      phy_irq_reg <= |(event_flag & event_en_reg);
    end
  end

  assign mack = mack_reg;
  assign mrdata = mrdata_reg;
  assign phy_irq = phy_irq_reg;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  sequence s_evt_read;
    mreq.req && !mreq.we && mreq.addr == `PHYIRQ_EVT_ADDR;
  endsequence

  sequence s_diag_read;
    mreq.req && !mreq.we && mreq.addr == `PHYIRQ_DIAG_ADDR;
  endsequence

  sequence s_quiet_evt;
    !(mreq.req && mreq.addr == `PHYIRQ_EVT_ADDR);
  endsequence

  sequence s_evt_write;
    mreq.req && mreq.we && mreq.addr == `PHYIRQ_EVT_ADDR;
  endsequence

  sequence s_unmapped_read;
    mreq.req && !mreq.we && !sel_evt && !sel_diag;
  endsequence

  a_jabber_flag_irq: assert property (
    events.jabber && event_en_reg[7] && !wr_evt ##1 s_quiet_evt |=> phy_irq)
    else $error("jabber with enable did not raise irq");

  a_rxerr_flag_set: assert property (
    events.rx_error |=> event_flag[6])
    else $error("rx error flag not set");

  a_page_flag_set: assert property (
    events.page_received |=> event_flag[5])
    else $error("page received flag not set");

  a_pdf_flag_set: assert property (
    events.par_detect_fault |=> event_flag[4])
    else $error("parallel detect fault flag not set");

  a_ack_flag_set: assert property (
    events.partner_ack |=> event_flag[3])
    else $error("partner ack flag not set");

  a_link_flag_set: assert property (
    events.link_drop |=> event_flag[2])
    else $error("link drop flag not set");

  a_rfault_flag_set: assert property (
    events.remote_fault |=> event_flag[1])
    else $error("remote fault flag not set");

  a_done_masked_quiet: assert property (
    events.negotiation_done && event_flag == '0 && event_en_reg == '0 && !wr_evt |=> ##1 !phy_irq)
    else $error("masked negotiation done raised irq");

  a_read_clears_flags: assert property (
    s_evt_read ##0 events == '0 |=> event_flag == '0 ##0 mack ##0 mrdata[7:0] == $past(event_flag))
    else $error("event read did not clear or return flags");

  a_irq_follows_gate: assert property (
    (event_flag & event_en_reg) != '0 |=> phy_irq)
    else $error("enabled flag did not raise irq");

  a_fail_until_read: assert property (
    neg.failed ##1 (!rd_diag && !neg.failed) [*2] |=> diag_word[`PHYIRQ_DIAG_FAIL_BIT])
    else $error("failure bit dropped before read");

  a_fail_cleared: assert property (
    s_diag_read ##0 !neg.failed |=> !diag_word[`PHYIRQ_DIAG_FAIL_BIT])
    else $error("failure bit not cleared by read");

  a_duplex_report: assert property (
    neg.done |=> diag_word[`PHYIRQ_DIAG_NEGOTIATED_FULL_DUPLEX_BIT] == $past(neg.full_duplex))
    else $error("duplex bit mismatch");

  a_rate_report: assert property (
    neg.done |=> diag_word[`PHYIRQ_DIAG_RATE_BIT] == $past(neg.fast))
    else $error("rate bit mismatch");

  a_rx_signal_detected_report: assert property (
    rx_sd [*2] |-> diag_word[`PHYIRQ_DIAG_RX_SIGNAL_DETECTED_BIT])
    else $error("signal detect bit mismatch");

  a_lock_report: assert property (
    !rx_lock [*2] |-> !diag_word[`PHYIRQ_DIAG_LOCK_BIT])
    else $error("lock bit mismatch");

  a_diag_reserved_zero: assert property (
    s_diag_read |=> mack && mrdata[15:13] == 3'h0 && mrdata[7:0] == 8'h00)
    else $error("reserved diagnostic bits not zero");

  a_diag_readonly: assert property (
    mreq.req && mreq.we && mreq.addr == `PHYIRQ_DIAG_ADDR && !neg.done && !neg.failed
      |=> diag_word[12:10] == $past(diag_word[12:10]))
    else $error("write changed diagnostic register");

  a_irq_quiet_masked: assert property (
    (event_flag & event_en_reg) == '0 |=> !phy_irq)
    else $error("irq without enabled flag");

  a_jabber_flag_set: assert property (
    events.jabber |=> event_flag[7])
    else $error("jabber flag not set");

  // No write in the event cycle keeps the enable fixed until the irq edge
  a_rxerr_gate_irq: assert property (
    events.rx_error && event_en_reg[6] && !wr_evt |=> ##1 phy_irq)
    else $error("enabled rx error did not raise irq");

  a_page_gate_irq: assert property (
    events.page_received && event_en_reg[5] && !wr_evt |=> ##1 phy_irq)
    else $error("enabled page received did not raise irq");

  a_pdf_gate_irq: assert property (
    events.par_detect_fault && event_en_reg[4] && !wr_evt |=> ##1 phy_irq)
    else $error("enabled parallel detect fault did not raise irq");

  a_ack_gate_irq: assert property (
    events.partner_ack && event_en_reg[3] && !wr_evt |=> ##1 phy_irq)
    else $error("enabled partner ack did not raise irq");

  a_link_gate_irq: assert property (
    events.link_drop && event_en_reg[2] && !wr_evt |=> ##1 phy_irq)
    else $error("enabled link drop did not raise irq");

  a_rfault_gate_irq: assert property (
    events.remote_fault && event_en_reg[1] && !wr_evt |=> ##1 phy_irq)
    else $error("enabled remote fault did not raise irq");

  a_done_flag_set: assert property (
    events.negotiation_done |=> event_flag[0])
    else $error("negotiation done flag not set");

  a_done_gate_irq: assert property (
    events.negotiation_done && event_en_reg[0] && !wr_evt |=> ##1 phy_irq)
    else $error("enabled negotiation done did not raise irq");

  a_flags_sticky: assert property (
    !rd_evt |=> (event_flag & $past(event_flag)) == $past(event_flag))
    else $error("flag dropped without a read");

  a_no_spurious_flag: assert property (
    events == '0 |=> (event_flag & ~$past(event_flag)) == '0)
    else $error("flag rose without an event");

  a_status_write_ignored: assert property (
    wr_evt && events == '0 |=> event_flag == $past(event_flag))
    else $error("write changed status byte");

  a_evt_read_enables: assert property (
    s_evt_read |=> mack && mrdata[15:8] == $past(event_en_reg))
    else $error("event read returned wrong enables");

  a_enable_write: assert property (
    s_evt_write |=> event_en_reg == $past(mreq.wdata[15:8]))
    else $error("enable write not taken");

  a_enable_hold: assert property (
    !wr_evt |=> $stable(event_en_reg))
    else $error("enables changed without a write");

  a_fail_set: assert property (
    neg.failed |=> diag_word[`PHYIRQ_DIAG_FAIL_BIT])
    else $error("failure bit not set");

  a_fail_hold: assert property (
    diag_word[`PHYIRQ_DIAG_FAIL_BIT] && !rd_diag |=> diag_word[`PHYIRQ_DIAG_FAIL_BIT])
    else $error("failure bit dropped without a read");

  a_fail_only_event: assert property (
    !diag_word[`PHYIRQ_DIAG_FAIL_BIT] && !neg.failed |=> !diag_word[`PHYIRQ_DIAG_FAIL_BIT])
    else $error("failure bit rose without a failure");

  a_fail_read_returns: assert property (
    s_diag_read ##0 diag_word[`PHYIRQ_DIAG_FAIL_BIT] |=> mrdata[`PHYIRQ_DIAG_FAIL_BIT])
    else $error("clearing read lost the failure bit");

  a_mode_hold: assert property (
    !neg.done |=> $stable(diag_word[`PHYIRQ_DIAG_NEGOTIATED_FULL_DUPLEX_BIT:`PHYIRQ_DIAG_RATE_BIT]))
    else $error("mode bits changed without a negotiation");

  a_rx_signal_detected_low: assert property (
    !rx_sd [*2] |-> !diag_word[`PHYIRQ_DIAG_RX_SIGNAL_DETECTED_BIT])
    else $error("signal detect bit set without signal");

  a_lock_high: assert property (
    rx_lock [*2] |-> diag_word[`PHYIRQ_DIAG_LOCK_BIT])
    else $error("lock bit clear while locked");

  a_diag_reserved_image: assert property (
    diag_word[15:13] == 3'h0 && diag_word[7:0] == 8'h00)
    else $error("reserved diagnostic image bits not zero");

  a_diag_read_data: assert property (
    s_diag_read |=> mack && mrdata == $past(diag_word))
    else $error("diagnostic read returned wrong word");

  a_unmapped_read_zero: assert property (
    s_unmapped_read |=> mack && mrdata == `PHYIRQ_UNMAPPED_READ)
    else $error("unmapped read not zero");

  a_ack_every_request: assert property (
    mreq.req |=> mack)
    else $error("request not answered");

  a_ack_only_request: assert property (
    !mreq.req |=> !mack)
    else $error("answer without a request");

  // Read data stands until the next read so a slow master still sees it
  a_rdata_hold: assert property (
    !(mreq.req && !mreq.we) |=> $stable(mrdata))
    else $error("read data changed without a read");

endmodule

`default_nettype wire

//--- core/phyirq_map.svh
// Register offsets, field positions and reset values of the PHY event and diagnostic registers
`ifndef PHYIRQ_MAP_SVH
`define PHYIRQ_MAP_SVH

`define PHYIRQ_ADDR_W 5
`define PHYIRQ_DATA_W 16

`define PHYIRQ_EVT_ADDR 5'h11
`define PHYIRQ_DIAG_ADDR 5'h12

`define PHYIRQ_EVT_RESET 16'h0000
`define PHYIRQ_DIAG_RESET 16'h0000
`define PHYIRQ_UNMAPPED_READ 16'h0000

`define PHYIRQ_EVT_FLAG_LSB 0
`define PHYIRQ_EVT_EN_LSB 8
`define PHYIRQ_EVT_COUNT 8

`define PHYIRQ_DIAG_FAIL_BIT 12
`define PHYIRQ_DIAG_NEGOTIATED_FULL_DUPLEX_BIT 11
`define PHYIRQ_DIAG_RATE_BIT 10
`define PHYIRQ_DIAG_RX_SIGNAL_DETECTED_BIT 9
`define PHYIRQ_DIAG_LOCK_BIT 8

`endif

//--- core/phyirq_pkg.sv
// Types shared by the PHY event and diagnostic register files
package phyirq_pkg;

  // Bit order matches the status byte, bit 7 first
  typedef struct packed {
    logic jabber;
    logic rx_error;
    logic page_received;
    logic par_detect_fault;
    logic partner_ack;
    logic link_drop;
    logic remote_fault;
    logic negotiation_done;
  } phyirq_event_s;

  typedef struct packed {
    logic req;
    logic we;
    logic [4:0] addr;
    logic [15:0] wdata;
  } phyirq_mreq_s;

  typedef struct packed {
    logic done;
    logic failed;
    logic full_duplex;
    logic fast;
  } phyirq_neg_s;

endpackage

//--- core/phyirq_flags.sv
// Sticky event flags with read clear, set winning over clear
`timescale 1ns/1ps
`default_nettype none

module phyirq_flags #(
  parameter int N = 8
) (
  input wire logic mclk, // Clock
  input wire logic srst, // Sync reset, high
  input wire logic [N-1:0] set_pulse, // Event pulses
  input wire logic clear_all, // Register read clear
  output logic [N-1:0] flag // Sticky flags
);

  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_flag
      always_ff @(posedge mclk) begin
        if (srst) begin
          flag[i] <= 1'b0;
        end else if (set_pulse[i]) begin
          // An event on the clearing read stays visible for the next read
          flag[i] <= 1'b1;
        end else if (clear_all) begin
          flag[i] <= 1'b0;
        end
      end
    end
  endgenerate

endmodule

`default_nettype wire

//--- core/phyirq_diag.sv
// Auto-negotiation outcome and receive state word
`timescale 1ns/1ps
`default_nettype none
`include "phyirq_map.svh"

module phyirq_diag (
  input wire logic mclk, // Clock
  input wire logic srst, // Sync reset, high
  input wire phyirq_pkg::phyirq_neg_s neg, // Negotiation outcome
  input wire logic rx_sd, // Receive signal detect
  input wire logic rx_lock, // Receive PLL lock
  input wire logic clear_fail, // Diagnostic read
  output logic [15:0] diag_word // Register image
);

  logic negotiation_failed_reg;
  logic negotiated_full_duplex_reg;
  logic negotiated_fast_reg;
  logic rx_signal_detected_reg;
  logic rx_lock_reg;

  always_ff @(posedge mclk) begin
    if (srst) begin
      negotiation_failed_reg <= 1'b0;
    end else if (neg.failed) begin
      negotiation_failed_reg <= 1'b1;
    end else if (clear_fail) begin
      negotiation_failed_reg <= 1'b0;
    end
  end

  // Best common mode only changes when a negotiation concludes
  always_ff @(posedge mclk) begin
    if (srst) begin
      negotiated_full_duplex_reg <= 1'b0;
      negotiated_fast_reg <= 1'b0;
    end else if (neg.done) begin
      negotiated_full_duplex_reg <= neg.full_duplex;
      negotiated_fast_reg <= neg.fast;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      rx_signal_detected_reg <= 1'b0;
      rx_lock_reg <= 1'b0;
    end else begin
      rx_signal_detected_reg <= rx_sd;
      rx_lock_reg <= rx_lock;
    end
  end

  always_comb begin
    diag_word = `PHYIRQ_DIAG_RESET;
    diag_word[`PHYIRQ_DIAG_FAIL_BIT] = negotiation_failed_reg;
    diag_word[`PHYIRQ_DIAG_NEGOTIATED_FULL_DUPLEX_BIT] = negotiated_full_duplex_reg;
    diag_word[`PHYIRQ_DIAG_RATE_BIT] = negotiated_fast_reg;
    diag_word[`PHYIRQ_DIAG_RX_SIGNAL_DETECTED_BIT] = rx_signal_detected_reg;
    diag_word[`PHYIRQ_DIAG_LOCK_BIT] = rx_lock_reg;
  end

endmodule

`default_nettype wire

//--- sim/phyirq_mac_model.sv
// Station management model issuing single register requests
`timescale 1ns/1ps
`default_nettype none

module phyirq_mac_model (
  input wire logic mclk, // Clock
  output var phyirq_pkg::phyirq_mreq_s mreq, // Management request
  input wire logic mack, // Request answered
  input wire logic [15:0] mrdata // Read data
);
  initial begin
    mreq = '0;
  end

  // Held up to the taking edge, answer taken one cycle on
  task automatic xfer(input logic we, input logic [4:0] addr, input logic [15:0] wdata,
                      output logic ack, output logic [15:0] rdata);
    @(posedge mclk);
    #1;
    mreq = '{req: 1'b1, we: we, addr: addr, wdata: wdata};
    @(posedge mclk);
    #1;
    ack = mack;
    rdata = mrdata;
    // Released lines carry inverted leftovers so a stale value cannot pass
    mreq = '{req: 1'b0, we: ~we, addr: ~addr, wdata: ~wdata};
  endtask
endmodule

`default_nettype wire

//--- sim/phy_irq_and_diag_regs_test.sv
// Self-checking bench of the PHY event and diagnostic registers
`timescale 1ns/1ps
`default_nettype none

`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin n_mismatch++; \
  $display("BAD %0t got %h want %h", $time, (a), (e)); end end

module phy_irq_and_diag_regs_test;
  logic mclk;
  logic srst;
  logic mack;
  logic phy_irq;
  logic rx_sd;
  logic rx_lock;
  logic [15:0] mrdata;
  phyirq_pkg::phyirq_mreq_s mreq;
  phyirq_pkg::phyirq_event_s events;
  phyirq_pkg::phyirq_neg_s neg;
  int n_mismatch = 0;
  int n_compared = 0;

  phyirq_regs dut (.mclk(mclk), .srst(srst), .mreq(mreq), .events(events), .neg(neg), .rx_sd(rx_sd),
    .rx_lock(rx_lock), .mack(mack), .mrdata(mrdata), .phy_irq(phy_irq));
  phyirq_mac_model mac (.mclk(mclk), .mreq(mreq), .mack(mack), .mrdata(mrdata));

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  task automatic cycles(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    logic ack;
    logic [15:0] d;
    mac.xfer(1'b0, a, 16'h0000, ack, d);
    `CHK(ack, 1'b1)
    `CHK(d, e)
  endtask

  task automatic wr(input logic [4:0] a, input logic [15:0] w);
    logic ack;
    logic [15:0] d;
    mac.xfer(1'b1, a, w, ack, d);
    `CHK(ack, 1'b1)
  endtask

  task automatic pulse(input logic [7:0] m);
    @(posedge mclk);
    #1;
    events = phyirq_pkg::phyirq_event_s'(m);
    cycles(1);
    events = '0;
  endtask

  task automatic neg_pulse(input logic [3:0] v);
    @(posedge mclk);
    #1;
    neg = phyirq_pkg::phyirq_neg_s'(v);
    cycles(1);
    neg = '0;
  endtask

  task automatic t_reset();
    `CHK(phy_irq, 1'b0)
    rd(5'h11, 16'h0000);
    rd(5'h12, 16'h0000);
  endtask

  // Each source alone, then its neighbour while masked
  task automatic t_events();
    for (int i = 0; i < 8; i++) begin
      logic [7:0] m;
      logic [7:0] n;
      m = 8'h01 << i;
      n = {m[6:0], m[7]};
      wr(5'h11, {m, 8'hFF});
      pulse(m);
      cycles(2);
      `CHK(phy_irq, 1'b1)
      rd(5'h11, {m, m});
      cycles(1);
      `CHK(phy_irq, 1'b0)
      pulse(n);
      cycles(2);
      `CHK(phy_irq, 1'b0)
      rd(5'h11, {m, n});
    end
  endtask

  task automatic t_diag();
    rx_sd = 1'b1;
    rx_lock = 1'b1;
    neg_pulse(4'hB);
    neg_pulse(4'h4);
    cycles(1);
    rd(5'h12, 16'h1F00);
    rd(5'h12, 16'h0F00);
    wr(5'h12, 16'hFFFF);
    rd(5'h12, 16'h0F00);
    rx_sd = 1'b0;
    rx_lock = 1'b0;
    neg_pulse(4'h8);
    cycles(1);
    rd(5'h12, 16'h0000);
    wr(5'h13, 16'hFFFF);
    rd(5'h13, 16'h0000);
  endtask

  // Event or failure on the clearing read edge survives for the next read
  task automatic t_collide();
    logic ack;
    logic [15:0] d;
    wr(5'h11, 16'h0100);
    pulse(8'h02);
    fork
      mac.xfer(1'b0, 5'h11, 16'h0000, ack, d);
      pulse(8'h01);
    join
    `CHK(d, 16'h0102)
    cycles(1);
    `CHK(phy_irq, 1'b1)
    rd(5'h11, 16'h0101);
    neg_pulse(4'h4);
    fork
      mac.xfer(1'b0, 5'h12, 16'h0000, ack, d);
      neg_pulse(4'h4);
    join
    `CHK(d, 16'h1000)
    rd(5'h12, 16'h1000);
    rd(5'h12, 16'h0000);
  endtask

  // Mid-run reset drops every enable, flag and diagnostic bit
  task automatic t_rereset();
    wr(5'h11, 16'hFF00);
    pulse(8'hFF);
    neg_pulse(4'hF);
    cycles(1);
    `CHK(phy_irq, 1'b1)
    srst = 1'b1;
    cycles(2);
    srst = 1'b0;
    `CHK(phy_irq, 1'b0)
    rd(5'h11, 16'h0000);
    rd(5'h12, 16'h0000);
  endtask

  task automatic tally_and_finish();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    srst = 1'b1;
    events = '0;
    neg = '0;
    rx_sd = 1'b0;
    rx_lock = 1'b0;
    repeat (5) @(posedge mclk);
    #1;
    srst = 1'b0;
    t_reset();
    t_events();
    t_diag();
    t_collide();
    t_rereset();
    tally_and_finish();
  end

  // Whole run is about 180 cycles; the 3000-cycle limit, over sixteen times that, means a hang
  initial begin
    #(4 * 3000);
    n_mismatch++;
    tally_and_finish();
  end
endmodule

`default_nettype wire
